// >>> hw/rsk_device.sv
// Timekeeper end: watches read cycles on the socket, unlocks on the key and
// moves the eight clock registers serially. Socket pins are synchronous to ref_clk.
// Function
// (R1) Unlock by 64 cycles; then detach memory
// (R2) Host uses only read cycles
// (R3) Select low: write, bit on data-in
// (R4) Select high: read, bit on data-out
// (R5) Cycle spans both strobes active
// (R6) Unlock needs 64 matching write cycles
// (R7) Host reads once before unlocking
// (R8) Read during hunt resets pointer
// (R9) Match advances; mismatch ignores later writes
// (R10) Key c5 3a a3 5c twice, lsb first
// (R11) Then 64 cycles each move one bit
// (R12) Foreign cycles do not disturb sequence
// (R13) Reset pin or power-up resets pointer
// (R14) Chip select blocked during transfer
// (R15) Power fail ignores inputs, aborts transfer
// (R16) Sweep bit 0 reg 0 to bit 7 reg 7
// (R17) Host handles whole eight-bit groups
// (R18) Register contents are BCD
// (R19) Hours bit7 12h mode, bit5 PM/tens
// (R20) Day bit4 disables reset pin
// (R21) Day bit5 stops oscillator, shipped set
// (R22) Unused bits read zero, writes accepted
`timescale 1ns/100ps
`default_nettype none
module rsk_device (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Socket
  rsk_if.device           link,
  // Local supply monitor and time-counting update port
  input  wire logic       power_fail,
  input  wire logic       upd_valid,
  input  wire logic [2:0] upd_index,
  input  wire logic [7:0] upd_data,
  // Status
  output logic            unlocked,
  output logic            sweep_done,
  output logic            osc_running,
  output logic            hour_12_mode,
  output logic            hour_pm,
  output logic            reset_pin_ignored
);
  rsk_pkg::rsk_dev_state_type state;
  rsk_pkg::rsk_dev_state_type next_state;
  logic [7:0] regs [rsk_pkg::NUM_REGS];
  logic [5:0] ptr;
  logic [5:0] next_ptr;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [7:0] shift;
  logic       cyc_active_q;

  // (R5) both strobes
  wire        cyc_active = ~link.ce_n & ~link.oe_n;
  wire        cyc_start  = cyc_active & ~cyc_active_q;
  wire        cyc_end    = ~cyc_active & cyc_active_q;
  wire        is_read    = link.rw_select_addr_line;
  wire        din        = link.serial_data_in_addr_line;
  // (R10) key bit compare
  wire        key_ok     = din == rsk_pkg::PATTERN[ptr];
  // (R13) (R15) (R20) abort sources
  wire        abort      = power_fail | (~link.module_rst_n & ~regs[rsk_pkg::REG_DAY][rsk_pkg::DAY_RST_DIS_BIT]);
  wire        take       = cyc_start & ~abort;
  wire [2:0]  reg_sel    = cnt[5:3];
  wire [2:0]  bit_sel    = cnt[2:0];
  wire [7:0]  byte_in    = {din, shift[7:1]};
  // (R3) write bit commit
  wire        commit     = take & (state == rsk_pkg::RSK_XFER) & ~is_read & (bit_sel == rsk_pkg::LAST_IN_BYTE);
  wire        upd_take   = upd_valid & ~power_fail & (state != rsk_pkg::RSK_XFER);

  always_comb begin
    next_state = state;
    next_ptr   = ptr;
    next_cnt   = cnt;
    if (abort) begin
      // (R13) pointer to bit 0
      next_state = rsk_pkg::RSK_HUNT;
      next_ptr   = 6'h00;
      next_cnt   = 6'h00;
    end else if (cyc_start) begin
      unique case (state)
        rsk_pkg::RSK_HUNT: begin
          if (is_read) begin
            // (R8) read aborts hunt
            next_ptr = 6'h00;
          end else if (!key_ok) begin
            // (R9) mismatch freezes pointer
            next_state = rsk_pkg::RSK_IGNORE;
          end else if (ptr == rsk_pkg::LAST_BIT) begin
            // (R1) (R6) all 64 matched
            next_state = rsk_pkg::RSK_XFER;
            next_ptr   = 6'h00;
            next_cnt   = 6'h00;
          end else begin
            // (R9) match advances
            next_ptr = ptr + 6'h01;
          end
        end
        rsk_pkg::RSK_IGNORE: begin
          // (R8) read restarts hunt
          if (is_read) begin
            next_state = rsk_pkg::RSK_HUNT;
            next_ptr   = 6'h00;
          end
        end
        rsk_pkg::RSK_XFER: begin
          // (R11) (R16) one bit per cycle
          next_cnt = cnt + 6'h01;
          if (cnt == rsk_pkg::LAST_BIT) begin
            next_state = rsk_pkg::RSK_HUNT;
            next_cnt   = 6'h00;
          end
        end
        default: begin
          next_state = rsk_pkg::RSK_HUNT;
          next_ptr   = 6'h00;
        end
      endcase
    end
  end

  // Only fully strobed cycles count, so foreign cycles leave the sequence alone
  // (R12) strobe-gated sequencing
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state        <= rsk_pkg::RSK_HUNT;
      ptr          <= 6'h00;
      cnt          <= 6'h00;
      cyc_active_q <= 1'b0;
    end else begin
      state        <= next_state;
      ptr          <= next_ptr;
      cnt          <= next_cnt;
      cyc_active_q <= cyc_active;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift <= 8'h00;
    end else if (take && state == rsk_pkg::RSK_XFER && !is_read) begin
      shift <= byte_in;
    end
  end

  // Bytes land whole on their eighth bit, so a half sent group never corrupts a register.
  // Registers keep their values across the reset pin; only power-up initialises them.
  genvar gi;
  generate
    for (gi = 0; gi < rsk_pkg::NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          // (R21) shipped control bits
          regs[gi] <= (gi == rsk_pkg::REG_DAY) ? rsk_pkg::DAY_RESET : rsk_pkg::OTHER_RESET;
        end else if (commit && reg_sel == 3'(gi)) begin
          // (R17) (R18) (R22) masked whole byte
          regs[gi] <= byte_in & rsk_pkg::reg_mask(3'(gi));
        end else if (upd_take && upd_index == 3'(gi)) begin
          // (R15) blocked on power fail
          regs[gi] <= upd_data & rsk_pkg::reg_mask(3'(gi));
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.serial_data_out_line <= 1'b0;
      link.serial_data_out_en   <= 1'b0;
    end else if (abort || cyc_end) begin
      link.serial_data_out_en <= 1'b0;
    end else if (take && state == rsk_pkg::RSK_XFER && is_read) begin
      // (R4) drive read bit
      link.serial_data_out_line <= regs[reg_sel][bit_sel];
      link.serial_data_out_en   <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.mem_ce_n     <= 1'b1;
      unlocked          <= 1'b0;
      sweep_done        <= 1'b0;
      osc_running       <= 1'b0;
      hour_12_mode      <= 1'b0;
      hour_pm           <= 1'b0;
      reset_pin_ignored <= 1'b0;
    end else begin
      // (R14) memory select blocked; held to the end of the last transfer cycle so the memory never
      // fights the data line while the final bit is still on it
      link.mem_ce_n     <= link.ce_n | (state == rsk_pkg::RSK_XFER) | (next_state == rsk_pkg::RSK_XFER) |
                           (link.mem_ce_n & cyc_active_q & cyc_active);
      unlocked          <= next_state == rsk_pkg::RSK_XFER;
      sweep_done        <= take & (state == rsk_pkg::RSK_XFER) & (cnt == rsk_pkg::LAST_BIT);
      // (R21) oscillator control
      osc_running       <= ~regs[rsk_pkg::REG_DAY][rsk_pkg::DAY_OSC_OFF_BIT];
      // (R19) hour format
      hour_12_mode      <= regs[rsk_pkg::REG_HOURS][rsk_pkg::HOUR_MODE_BIT];
      hour_pm           <= regs[rsk_pkg::REG_HOURS][rsk_pkg::HOUR_MODE_BIT] &
                           regs[rsk_pkg::REG_HOURS][rsk_pkg::HOUR_PM_BIT];
      reset_pin_ignored <= regs[rsk_pkg::REG_DAY][rsk_pkg::DAY_RST_DIS_BIT];
    end
  end
endmodule
`default_nettype wire

// >>> hw/rsk_host.sv
// Host bus end: FIFO for bytes to be written, and the sequencer that issues
// socket read cycles for reset, unlock and one full register sweep.
// Assumes the timekeeper end answers on the same ref_clk.
`timescale 1ns/100ps
`default_nettype none
module rsk_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  wire              push       = in_valid & in_ready;
  wire              pop        = out_valid & out_ready;
  wire [CW-1:0]     next_count = count + CW'(push) - CW'(pop);

  assign out_data = mem[rd_ptr];

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      wr_ptr    <= push ? AW'((wr_ptr + 1'b1) % DEPTH) : wr_ptr;
      rd_ptr    <= pop ? AW'((rd_ptr + 1'b1) % DEPTH) : rd_ptr;
      count     <= next_count;
      in_ready  <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule

module rsk_host #(
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  // Socket
  rsk_if.host             link,
  // Sweep command
  input  wire logic       cmd_valid,
  input  wire logic       cmd_write,
  output logic            cmd_ready,
  // Bytes to write, register 0 first
  input  wire logic       wr_valid,
  input  wire logic [7:0] wr_data,
  output logic            wr_ready,
  // Bytes read, register 0 first
  output logic            rd_valid,
  output logic [7:0]      rd_data
);
  rsk_pkg::rsk_host_state_type state;
  rsk_pkg::rsk_host_state_type next_state;
  logic [7:0] step;
  logic [7:0] next_step;
  logic [3:0] tmr;
  logic       wmode;
  logic [7:0] shift;
  logic [7:0] rbuf;
  logic       fifo_valid;
  logic [7:0] fifo_data;

  wire        in_xfer   = step >= rsk_pkg::HOST_FIRST_XFER;
  wire [5:0]  xbit      = 6'(step - rsk_pkg::HOST_FIRST_XFER);
  wire [7:0]  nxbit     = next_step - rsk_pkg::HOST_FIRST_XFER;
  wire        need_byte = wmode & (next_step >= rsk_pkg::HOST_FIRST_XFER) & (nxbit[2:0] == 3'h0);
  wire        tmr_done  = tmr == 4'h0;
  wire        fifo_pop  = (state == rsk_pkg::RSK_LOAD) & fifo_valid;
  wire        low_end   = (state == rsk_pkg::RSK_LOW) & tmr_done;
  // (R7) step 0 is a read; (R3) unlock and write steps hold select low
  wire        next_rw   = (next_step == 8'h00) | ((next_step >= rsk_pkg::HOST_FIRST_XFER) & ~wmode);
  wire [5:0]  nkey      = 6'(next_step - 8'h01);
  wire        next_din  = (next_step >= rsk_pkg::HOST_FIRST_XFER) ? (fifo_pop ? fifo_data[0] : shift[0])
                                                                   : rsk_pkg::PATTERN[nkey];

  rsk_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk   (ref_clk),
    .resetn    (resetn),
    .in_valid  (wr_valid),
    .in_ready  (wr_ready),
    .in_data   (wr_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  always_comb begin
    next_state = state;
    next_step  = step;
    unique case (state)
      rsk_pkg::RSK_IDLE: begin
        if (cmd_valid) begin
          next_state = rsk_pkg::RSK_LOW;
          next_step  = 8'h00;
        end
      end
      rsk_pkg::RSK_LOW: begin
        if (tmr_done) begin
          next_state = rsk_pkg::RSK_HIGH;
        end
      end
      rsk_pkg::RSK_HIGH: begin
        if (tmr_done) begin
          if (step == rsk_pkg::HOST_LAST_STEP) begin
            next_state = rsk_pkg::RSK_IDLE;
          end else begin
            next_step  = step + 8'h01;
            next_state = need_byte ? rsk_pkg::RSK_LOAD : rsk_pkg::RSK_LOW;
          end
        end
      end
      rsk_pkg::RSK_LOAD: begin
        // Stalls here while the FIFO is empty; strobes stay high meanwhile
        if (fifo_valid) begin
          next_state = rsk_pkg::RSK_LOW;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state <= rsk_pkg::RSK_IDLE;
      step  <= 8'h00;
      tmr   <= 4'h0;
      wmode <= 1'b0;
    end else begin
      state <= next_state;
      step  <= next_step;
      if (state == rsk_pkg::RSK_IDLE && cmd_valid) begin
        wmode <= cmd_write;
      end
      if (next_state != state) begin
        tmr <= (next_state == rsk_pkg::RSK_LOW) ? 4'(rsk_pkg::CYC_LOW_CLKS - 1) : 4'(rsk_pkg::CYC_HIGH_CLKS - 1);
      end else if (!tmr_done) begin
        tmr <= tmr - 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      shift    <= 8'h00;
      rbuf     <= 8'h00;
      rd_valid <= 1'b0;
      rd_data  <= 8'h00;
    end else begin
      rd_valid <= 1'b0;
      if (fifo_pop) begin
        shift <= fifo_data;
      end else if (low_end && in_xfer && wmode) begin
        shift <= {1'b0, shift[7:1]};
      end
      // (R16) lsb first; (R17) whole bytes out
      if (low_end && in_xfer && !wmode) begin
        rbuf <= {link.serial_data_out_wire, rbuf[7:1]};
        if (xbit[2:0] == rsk_pkg::LAST_IN_BYTE) begin
          rd_valid <= 1'b1;
          rd_data  <= {link.serial_data_out_wire, rbuf[7:1]};
        end
      end
    end
  end

  // (R2) every transfer is a read cycle: both strobes low, never a write strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      link.ce_n                     <= 1'b1;
      link.oe_n                     <= 1'b1;
      link.rw_select_addr_line      <= 1'b1;
      link.serial_data_in_addr_line <= 1'b0;
      link.module_rst_n             <= 1'b1;
      cmd_ready                     <= 1'b0;
    end else begin
      // (R5) strobes frame the cycle
      link.ce_n         <= next_state != rsk_pkg::RSK_LOW;
      link.oe_n         <= next_state != rsk_pkg::RSK_LOW;
      link.module_rst_n <= 1'b1;
      cmd_ready         <= next_state == rsk_pkg::RSK_IDLE;
      if (next_state == rsk_pkg::RSK_LOW && state != rsk_pkg::RSK_LOW) begin
        link.rw_select_addr_line      <= next_rw;
        // (R10) key then data bits
        link.serial_data_in_addr_line <= next_din;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hw/rsk_if.sv
// Socket signals between the host bus end and the timekeeper end.
// The testbench instantiates it twice; both modports are connected on the first, only the device modport on the second.
`timescale 1ns/100ps
`default_nettype none
interface rsk_if;
  logic ce_n;
  logic oe_n;
  logic rw_select_addr_line;
  logic serial_data_in_addr_line;
  logic module_rst_n;
  logic serial_data_out_line;
  logic serial_data_out_en;
  logic mem_ce_n;
  logic serial_data_out_wire;

  // Data line idles high when the timekeeper does not drive it
  assign serial_data_out_wire = serial_data_out_en ? serial_data_out_line : 1'b1;

  modport device (
    input  ce_n, oe_n, rw_select_addr_line, serial_data_in_addr_line, module_rst_n,
    output serial_data_out_line, serial_data_out_en, mem_ce_n
  );
  modport host (
    output ce_n, oe_n, rw_select_addr_line, serial_data_in_addr_line, module_rst_n,
    input  serial_data_out_wire, mem_ce_n
  );
endinterface
`default_nettype wire

// >>> hw/rsk_pkg.sv
// Constants, types and the unlock key shared by both ends of the socket timekeeper link.
// Assumes a single 20 MHz ref_clk on both ends.
package rsk_pkg;
  localparam int          CLK_PERIOD_NS   = 50;
  localparam int          PATTERN_BITS    = 64;
  localparam int          XFER_BITS       = 64;
  localparam int          NUM_REGS        = 8;
  // Key bytes c5 3a a3 5c c5 3a a3 5c, byte 0 in the low bits, sent lsb first
  localparam logic [63:0] PATTERN         = 64'h5ca3_3ac5_5ca3_3ac5;
  localparam logic [5:0]  LAST_BIT        = 6'h3f;
  localparam logic [2:0]  LAST_IN_BYTE    = 3'h7;
  localparam int          REG_HOURS       = 3;
  localparam int          REG_DAY         = 4;
  localparam int          HOUR_MODE_BIT   = 7;
  localparam int          HOUR_PM_BIT     = 5;
  localparam int          DAY_RST_DIS_BIT = 4;
  localparam int          DAY_OSC_OFF_BIT = 5;
  localparam logic [7:0]  DAY_RESET       = 8'h30;
  localparam logic [7:0]  OTHER_RESET     = 8'h00;
  // Implemented bits per register, register 0 in the low byte
  localparam logic [63:0] REG_MASKS       = 64'hff1f_3f37_bf7f_7fff;
  // Host bus cycle timing, strobes low and strobes high
  localparam int          CYC_LOW_NS      = 200;
  localparam int          CYC_HIGH_NS     = 200;
  localparam int          CYC_LOW_CLKS    = (CYC_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CYC_HIGH_CLKS   = (CYC_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0]  HOST_LAST_STEP  = 8'h80;
  localparam logic [7:0]  HOST_FIRST_XFER = 8'h41;

  typedef enum logic [1:0] {RSK_HUNT, RSK_IGNORE, RSK_XFER} rsk_dev_state_type;
  typedef enum logic [1:0] {RSK_IDLE, RSK_LOW, RSK_HIGH, RSK_LOAD} rsk_host_state_type;

  function automatic logic [7:0] reg_mask(input logic [2:0] idx);
    reg_mask = REG_MASKS[{idx, 3'h0} +: 8];
  endfunction
endpackage

// >>> tb/rom_socket_serial_timekeeper_bench.sv
// Host end and timekeeper end on one socket, and a second timekeeper whose
// socket the bench drives itself to break the host's rules on purpose.
`timescale 1ns/100ps
`default_nettype none
module rom_socket_serial_timekeeper_bench;
  localparam time DLY = 1ns;
  logic        ref_clk, resetn, cmd_valid, cmd_write, cmd_ready, wr_valid, wr_ready, rd_valid;
  logic [7:0]  wr_data, rd_data, upd_data, b0, got;
  logic        upd_valid, upd_valid_b, power_fail_b, q;
  logic [2:0]  upd_index;
  logic        hour_12_mode, hour_pm, osc_running, reset_pin_ignored, unlocked_b, ignored_b, done_a;
  logic [31:0] seed;
  logic [7:0]  exp_q[$];
  logic [7:0]  wbuf[32];
  int          mismatches, n_tests, n_done;

  rsk_if link_a ();
  rsk_if link_b ();
  rsk_host u_rsk_host (.ref_clk(ref_clk), .resetn(resetn), .link(link_a.host), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_ready(cmd_ready), .wr_valid(wr_valid), .wr_data(wr_data),
    .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data));
  rsk_device u_rsk_device (.ref_clk(ref_clk), .resetn(resetn), .link(link_a.device), .power_fail(1'b0),
    .upd_valid(upd_valid), .upd_index(upd_index), .upd_data(upd_data), .unlocked(), .sweep_done(done_a),
    .osc_running(osc_running), .hour_12_mode(hour_12_mode), .hour_pm(hour_pm),
    .reset_pin_ignored(reset_pin_ignored));
  rsk_device u_rsk_device_b (.ref_clk(ref_clk), .resetn(resetn), .link(link_b.device),
    .power_fail(power_fail_b), .upd_valid(upd_valid_b), .upd_index(upd_index), .upd_data(upd_data),
    .unlocked(unlocked_b), .sweep_done(), .osc_running(), .hour_12_mode(), .hour_pm(),
    .reset_pin_ignored(ignored_b));
  rsk_asserts u_rsk_asserts (.ref_clk(ref_clk), .resetn(resetn), .ce_n(link_a.ce_n), .oe_n(link_a.oe_n),
    .rw_select_addr_line(link_a.rw_select_addr_line), .serial_data_in_addr_line(link_a.serial_data_in_addr_line),
    .serial_data_out_en(link_a.serial_data_out_en), .mem_ce_n(link_a.mem_ce_n));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #DLY;
  endtask

  task automatic upd(input logic b, input logic [2:0] idx, input logic [7:0] d);
    upd_index   = idx;
    upd_data    = d;
    upd_valid   = !b;
    upd_valid_b = b;
    tick(1);
    upd_valid   = 1'b0;
    upd_valid_b = 1'b0;
    tick(1);
  endtask

  // A request is taken at the edge where ready was already high before it
  task automatic sweep(input logic w);
    int n;
    n         = 0;
    cmd_write = w;
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1) tick(1);
    tick(1);
    cmd_valid = 1'b0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check({7'h00, cmd_ready}, 8'h01);
  endtask

  // One socket cycle on the second link; the data line is sampled late in the low phase
  task automatic bcyc(input logic rd, input logic d);
    link_b.ce_n                     = 1'b0;
    link_b.oe_n                     = 1'b0;
    link_b.rw_select_addr_line      = rd;
    link_b.serial_data_in_addr_line = d;
    tick(4);
    q                               = link_b.serial_data_out_wire;
    link_b.ce_n                     = 1'b1;
    link_b.oe_n                     = 1'b1;
    link_b.serial_data_in_addr_line = ~d;
    tick(4);
    // Cycle elsewhere on the bus: output enable alone
    seed = lfsr(seed);
    if (seed[0]) begin
      link_b.oe_n = 1'b0;
      tick(2);
      link_b.oe_n = 1'b1;
      tick(2);
    end
  endtask

  task automatic send_key(input int upto, input int bad);
    for (int i = 0; i < upto; i++) bcyc(1'b0, rsk_pkg::PATTERN[i] ^ (i == bad));
  endtask

  task automatic unlock_read(input logic [7:0] exp);
    bcyc(1'b1, 1'b0);
    send_key(64, -1);
    check({7'h00, unlocked_b}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      bcyc(1'b1, 1'b0);
      got[i] = q;
    end
    check(got, exp);
  endtask

  always @(posedge ref_clk) begin
    if (done_a === 1'b1) n_done++;
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(rd_data, 8'hxx);
      else check(rd_data, exp_q.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end

  initial begin
    {cmd_valid, cmd_write, wr_valid, upd_valid, upd_valid_b, power_fail_b} = 6'h00;
    {wr_data, upd_data, upd_index} = 19'h00000;
    {link_b.ce_n, link_b.oe_n, link_b.rw_select_addr_line, link_b.module_rst_n} = 4'hf;
    link_b.serial_data_in_addr_line = 1'b0;
    mismatches = 0;
    n_tests    = 0;
    n_done     = 0;
    seed       = 32'h08560e5e;
    resetn     = 1'b0;
    tick(12);
    resetn = 1'b1;
    tick(2);
    check({7'h00, reset_pin_ignored}, 8'h01);
    check({7'h00, osc_running}, 8'h00);
    $display("test reset values done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      upd(1'b0, 3'(i), seed[7:0]);
      exp_q.push_back(seed[7:0] & rsk_pkg::REG_MASKS[i * 8 +: 8]);
    end
    sweep(1'b0);
    tick(2);
    check(8'(exp_q.size()), 8'h00);
    $display("test local load and read sweep done");
    for (int k = 0; k < 32; k++) begin
      seed    = lfsr(seed);
      wbuf[k] = (k % 8 == 3) ? (k[3] ? 8'ha1 : 8'h21) : (k % 8 == 4) ? (k[3] ? 8'h11 : 8'h30) : seed[7:0];
      wr_data  = wbuf[k];
      wr_valid = 1'b1;
      while (wr_ready !== 1'b1) tick(1);
      tick(1);
    end
    wr_valid = 1'b0;
    check({7'h00, wr_ready}, 8'h00);
    for (int j = 0; j < 4; j++) begin
      sweep(1'b1);
      tick(2);
      check({7'h00, hour_12_mode}, {7'h00, j[0]});
      check({7'h00, hour_pm}, {7'h00, j[0]});
      check({7'h00, osc_running}, {7'h00, j[0]});
      for (int i = 0; i < 8; i++) exp_q.push_back(wbuf[j * 8 + i] & rsk_pkg::REG_MASKS[i * 8 +: 8]);
      sweep(1'b0);
      tick(2);
    end
    check({7'h00, wr_ready}, 8'h01);
    $display("test write sweeps through full buffer done");
    seed = lfsr(seed);
    b0   = seed[7:0];
    upd(1'b1, 3'h0, b0);
    bcyc(1'b1, 1'b0);
    send_key(64, 10);
    check({7'h00, unlocked_b}, 8'h00);
    bcyc(1'b1, 1'b0);
    send_key(21, -1);
    unlock_read(b0);
    link_b.module_rst_n = 1'b0;
    tick(2);
    link_b.module_rst_n = 1'b1;
    tick(1);
    check({7'h00, unlocked_b}, 8'h01);
    // Local updates are held off while a sweep is open, so finish it first
    for (int i = 8; i < 64; i++) bcyc(1'b1, 1'b0);
    check({7'h00, unlocked_b}, 8'h00);
    upd(1'b1, 3'h4, 8'h00);
    tick(2);
    check({7'h00, ignored_b}, 8'h00);
    unlock_read(b0);
    link_b.module_rst_n = 1'b0;
    tick(2);
    link_b.module_rst_n = 1'b1;
    tick(1);
    check({7'h00, unlocked_b}, 8'h00);
    unlock_read(b0);
    power_fail_b = 1'b1;
    tick(2);
    check({7'h00, unlocked_b}, 8'h00);
    upd(1'b1, 3'h0, ~b0);
    power_fail_b = 1'b0;
    tick(1);
    unlock_read(b0);
    $display("test key, abort and reset on second link done");
    check(8'(n_done), 8'h09);
    summarize();
  end
endmodule
`default_nettype wire

// >>> tb/rsk_asserts.sv
// Checks on the socket signals between the host end and the timekeeper end.
// Assumes a host that sends whole sweeps, each opened by one read cycle.
`timescale 1ns/100ps
`default_nettype none
module rsk_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Socket
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic rw_select_addr_line,
  input wire logic serial_data_in_addr_line,
  input wire logic serial_data_out_en,
  input wire logic mem_ce_n
);
  logic       both_low_q;
  logic [7:0] step;
  logic [7:0] next_step;
  logic       start;
  logic [5:0] key_idx;

  // Step numbers the cycles of a sweep: 1 opening read, 2..65 key, 66..129 data
  assign start     = !ce_n && !oe_n && !both_low_q;
  assign key_idx   = step[5:0] - 6'h01;
  assign next_step = (rw_select_addr_line && (step == 8'h00 || step > 8'h80)) ? 8'h01 : step + 8'h01;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      both_low_q <= 1'b0;
      step       <= 8'h00;
    end else begin
      both_low_q <= !ce_n && !oe_n;
      step       <= start ? next_step : step;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence key_write;
    start && !rw_select_addr_line && step >= 8'h01 && step <= 8'h40;
  endsequence
  sequence data_read;
    start && rw_select_addr_line && step >= 8'h41 && step <= 8'h80;
  endsequence

  strobe_pair_a: assert property (ce_n == oe_n)
    else $error("strobes split");
  low_phase_a: assert property ($fell(ce_n) |-> !ce_n [*4] ##1 ce_n)
    else $error("strobe low phase length");
  addr_stable_a: assert property (!ce_n && $past(!ce_n) |-> $stable(rw_select_addr_line)
    && $stable(serial_data_in_addr_line)) else $error("address lines moved in cycle");
  key_bits_a: assert property (key_write |-> serial_data_in_addr_line == rsk_pkg::PATTERN[key_idx])
    else $error("key bit wrong");
  read_drive_a: assert property (data_read |-> ##[1:2] serial_data_out_en)
    else $error("data line not driven");
  drive_read_a: assert property (serial_data_out_en |-> rw_select_addr_line)
    else $error("data line driven in write cycle");
  line_release_a: assert property ($rose(ce_n) |-> ##[0:2] !serial_data_out_en)
    else $error("data line held after cycle");
  mem_detach_a: assert property (!ce_n && step >= 8'h42 && step <= 8'h81 |-> mem_ce_n)
    else $error("memory selected during transfer");
  mem_pass_a: assert property (!ce_n && $past(!ce_n) && step <= 8'h40 |-> !mem_ce_n)
    else $error("memory select blocked while hunting");
endmodule
`default_nettype wire
